// ===== hw/iop_top.sv
/*
 * field i/o conditioner: digital line polarity, mapping, virtual channels,
 * output forcing, analog filter, scaling and loss-of-signal trip, apb slave.
 * assumes adc samples arrive on pclk with a one-cycle valid strobe and
 * that field input pins are asynchronous.
 */
`timescale 1ns/1ps
`include "iop_params.svh"
module iop_top #(
    parameter int NIN      = 8,
    parameter int NOUT     = 4,
    parameter int SAMPLE_HZ = `IOP_SAMPLE_HZ,
    parameter bit HAS_RANGE = 1'b1
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [NIN-1:0]    din_pin,
    input  wire logic [7:0]        func_out,
    output logic      [7:0]        func_in,
    output logic      [NOUT-1:0]   dout_pin,
    input  wire logic [15:0]       adc_data,
    input  wire logic              adc_valid,
    output logic      [15:0]       ana_cmd,
    output logic                   signal_lost_fault,
    output logic                   ana_hold,
    output logic                   irq
);
    import iop_pkg::*;

    // coefficient in q16 per hertz: 2*pi*65536 / sample rate
    localparam int COEF_PER_HZ = (411775 + SAMPLE_HZ / 2) / SAMPLE_HZ;

    logic [31:0] ctrl_q, pol_q, force_q, imap_q, omap_q, vio_q, bw_q;
    logic [31:0] imap_act_q, omap_act_q;
    logic [15:0] vmin_q, vmax_q, trlo_q, trhi_q, cmin_q, cmax_q;
    logic [15:0] vmin_sv_q, vmax_sv_q;
    logic [2:0]  ist_q, imask_q;
    logic [NIN-1:0] sy1_q, sy2_q;
    logic        wr, rd_setup, hit;
    logic [31:0] rdat;
    logic signed [31:0] filt_q;

    assign wr       = psel & penable & pwrite;
    assign rd_setup = psel & ~penable;
    assign pready   = 1'b1;

    always_comb begin
        hit  = 1'b1;
        rdat = 32'h0;
        unique case (paddr)
            `IOP_A_CTRL:    rdat = {23'h0, ctrl_q[`IOP_C_FACT:`IOP_C_UNIP], 4'h0};
            `IOP_A_POL:     rdat = pol_q;
            `IOP_A_FORCE:   rdat = force_q;
            `IOP_A_IMAP:    rdat = imap_q;
            `IOP_A_OMAP:    rdat = omap_q;
            `IOP_A_VIO:     rdat = vio_q;
            `IOP_A_BW:      rdat = bw_q;
            `IOP_A_VMIN:    rdat = {16'h0, vmin_q};
            `IOP_A_VMAX:    rdat = {16'h0, vmax_q};
            `IOP_A_TRIPLO:  rdat = {16'h0, trlo_q};
            `IOP_A_TRIPHI:  rdat = {16'h0, trhi_q};
            `IOP_A_CMDMIN:  rdat = {16'h0, cmin_q};
            `IOP_A_CMDMAX:  rdat = {16'h0, cmax_q};
            `IOP_A_IOSTAT:  rdat = {func_in, 4'h0, 4'(dout_pin), 8'h0, 8'(sy2_q)};
            `IOP_A_ANASTAT: rdat = {ana_cmd, filt_q[31:16]};
            `IOP_A_ISTAT:   rdat = {29'h0, ist_q};
            `IOP_A_IMASK:   rdat = {29'h0, imask_q};
            `IOP_A_SAVED:   rdat = {vmax_sv_q, vmin_sv_q};
            default:        hit  = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else if (rd_setup) begin
            prdata  <= pwrite ? 32'h0 : rdat;
            pslverr <= ~hit;
        end
    end

    logic dnld, cap_min, cap_max, frst;
    assign dnld    = wr & (paddr == `IOP_A_CTRL) & pwdata[`IOP_C_DNLD];
    assign cap_min = wr & (paddr == `IOP_A_CTRL) & pwdata[`IOP_C_CAPMIN];
    assign cap_max = wr & (paddr == `IOP_A_CTRL) & pwdata[`IOP_C_CAPMAX];
    assign frst    = wr & (paddr == `IOP_A_CTRL) & pwdata[`IOP_C_FRST];

    logic signed [15:0] x_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= 32'h0;
            pol_q   <= 32'h0;
            force_q <= 32'h0;
            imap_q  <= 32'h0;
            omap_q  <= 32'h0;
            vio_q   <= 32'h0;
            bw_q    <= {16'h0, `IOP_RST_BW};
            vmin_q  <= `IOP_RST_VMIN;
            vmax_q  <= `IOP_RST_VMAX;
            trlo_q  <= `IOP_RST_VMIN;
            trhi_q  <= `IOP_RST_VMAX;
            cmin_q  <= `IOP_RST_VMIN;
            cmax_q  <= `IOP_RST_VMAX;
            imask_q <= 3'h0;
        end else begin
            if (wr) begin
                unique case (paddr)
                    // legacy enable bit is dropped: input is always on
                    `IOP_A_CTRL:   ctrl_q  <= {23'h0, pwdata[`IOP_C_FACT], 1'b0,
                                               pwdata[`IOP_C_HIEN:`IOP_C_UNIP], 4'h0};
                    `IOP_A_POL:    pol_q   <= pwdata;
                    `IOP_A_FORCE:  force_q <= pwdata;
                    `IOP_A_IMAP:   imap_q  <= pwdata;
                    `IOP_A_OMAP:   omap_q  <= pwdata;
                    `IOP_A_VIO:    vio_q   <= pwdata;
                    `IOP_A_BW:     bw_q    <= {16'h0, pwdata[15:0]};
                    `IOP_A_VMIN:   vmin_q  <= pwdata[15:0];
                    `IOP_A_VMAX:   vmax_q  <= pwdata[15:0];
                    `IOP_A_TRIPLO: trlo_q  <= pwdata[15:0];
                    `IOP_A_TRIPHI: trhi_q  <= pwdata[15:0];
                    `IOP_A_CMDMIN: cmin_q  <= pwdata[15:0];
                    `IOP_A_CMDMAX: cmax_q  <= pwdata[15:0];
                    `IOP_A_IMASK:  imask_q <= pwdata[2:0];
                    default: ;
                endcase
            end
            if (cap_min) vmin_q <= x_q;
            if (cap_max) vmax_q <= x_q;
        end
    end

    // maps and saved endpoints follow the edits only on download
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imap_act_q <= 32'h0;
            omap_act_q <= 32'h0;
            vmin_sv_q  <= `IOP_RST_VMIN;
            vmax_sv_q  <= `IOP_RST_VMAX;
        end else if (dnld) begin
            imap_act_q <= imap_q;
            omap_act_q <= omap_q;
            vmin_sv_q  <= vmin_q;
            vmax_sv_q  <= vmax_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sy1_q <= '0;
            sy2_q <= '0;
        end else begin
            sy1_q <= din_pin;
            sy2_q <= sy1_q;
        end
    end

    logic [7:0] fin_d;
    always_comb begin
        fin_d = 8'h0;
        for (int i = 0; i < NIN; i++) begin
            if (sy2_q[i] ^ pol_q[i])
                fin_d[iop_fld3(imap_act_q, i)] = 1'b1;
        end
        // virtual channels win over the pins for the chosen function
        // bit 7 of each channel enables it, so an unassigned channel routes nothing
        for (int k = 0; k < 2; k++) begin
            if (vio_q[9*k+7] && func_out[iop_fld3(vio_q, 3*k)])
                fin_d[iop_fld3(vio_q, 3*k+1)] = vio_q[9*k+6];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) func_in <= 8'h0;
        else          func_in <= fin_d;
    end

    genvar j;
    generate
        for (j = 0; j < NOUT; j++) begin : g_out
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    dout_pin[j] <= 1'b0;
                else if (force_q[j])
                    dout_pin[j] <= 1'b1;
                else if (force_q[8+j])
                    dout_pin[j] <= 1'b0;
                else
                    dout_pin[j] <= func_out[iop_fld3(omap_act_q, j)] ^ pol_q[8+j];
            end
        end
    endgenerate

    // analog path: unipolar mode clips negative codes to zero
    logic signed [15:0] x_d;
    always_comb begin
        x_d = adc_data;
        if (HAS_RANGE && ctrl_q[`IOP_C_UNIP] && adc_data[15])
            x_d = 16'h0000;
    end

    logic        [16:0] alpha;
    logic signed [32:0] ferr;
    logic signed [50:0] fstep;
    logic        [31:0] coef_w;
    assign coef_w = bw_q[15:0] * 32'(COEF_PER_HZ);
    assign alpha  = (coef_w > 32'h0001_0000) ? 17'h10000 : coef_w[16:0];
    assign ferr   = {x_d[15], x_d, 16'h0} - {filt_q[31], filt_q};
    assign fstep  = (ferr * $signed({1'b0, alpha})) >>> 16;
    assign ana_hold = (bw_q[15:0] == 16'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            x_q    <= 16'h0;
            filt_q <= 32'h0;
        end else if (adc_valid) begin
            x_q    <= x_d;
            filt_q <= filt_q + fstep[31:0];
        end
    end

    // scaler starts a cycle after the sample so it sees the updated filter
    logic go_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) go_q <= 1'b0;
        else          go_q <= adc_valid;
    end

    // scaling: cmin + (yc - vmin) * (cmax - cmin) / (vmax - vmin), yc being y clamped to vmin..vmax
    iop_div_st_t        st_q;
    logic        [5:0]  cnt_q;
    logic        [33:0] quo_q;
    logic        [17:0] rem_q;
    logic        [16:0] den_q;
    logic               neg_q;
    logic signed [15:0] y, yc;
    logic signed [33:0] num;
    logic        [17:0] rsh;
    logic signed [16:0] den_w;
    assign y     = filt_q[31:16];
    assign yc    = (y < $signed(vmin_q)) ? $signed(vmin_q) :
                   (y > $signed(vmax_q)) ? $signed(vmax_q) : y;
    assign num   = 34'($signed({yc[15], yc} - {vmin_q[15], vmin_q}) *
                   $signed({cmax_q[15], cmax_q} - {cmin_q[15], cmin_q}));
    assign den_w = {vmax_q[15], vmax_q} - {vmin_q[15], vmin_q};
    assign rsh   = {rem_q[16:0], quo_q[33]};

    logic signed [16:0] qs;
    assign qs = neg_q ? -$signed(quo_q[16:0]) : $signed(quo_q[16:0]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q    <= IOP_DIV_IDLE;
            cnt_q   <= 6'h0;
            quo_q   <= 34'h0;
            rem_q   <= 18'h0;
            den_q   <= 17'h0;
            neg_q   <= 1'b0;
            ana_cmd <= 16'h0;
        end else begin
            unique case (st_q)
                IOP_DIV_IDLE: if (go_q) begin
                    if (den_w <= 0) begin
                        ana_cmd <= cmin_q;
                    end else begin
                        st_q  <= IOP_DIV_RUN;
                        cnt_q <= 6'(`IOP_DIV_STEPS);
                        neg_q <= num[33];
                        quo_q <= num[33] ? -num : num;
                        rem_q <= 18'h0;
                        den_q <= den_w;
                    end
                end
                IOP_DIV_RUN: begin
                    if (rsh >= {1'b0, den_q}) begin
                        rem_q <= rsh - {1'b0, den_q};
                        quo_q <= {quo_q[32:0], 1'b1};
                    end else begin
                        rem_q <= rsh;
                        quo_q <= {quo_q[32:0], 1'b0};
                    end
                    cnt_q <= cnt_q - 6'h1;
                    if (cnt_q == 6'h0) begin
                        st_q <= IOP_DIV_IDLE;
                        // the fault action may park the command at its minimum
                        ana_cmd <= (signal_lost_fault && ctrl_q[`IOP_C_FACT]) ?
                                   cmin_q : 16'(cmin_q + qs[15:0]);
                    end
                end
            endcase
        end
    end

    logic trip;
    assign trip = (ctrl_q[`IOP_C_LOEN] && x_q < $signed(trlo_q)) ||
                  (ctrl_q[`IOP_C_HIEN] && x_q > $signed(trhi_q));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)   signal_lost_fault <= 1'b0;
        else if (trip)  signal_lost_fault <= 1'b1;
        else if (frst)  signal_lost_fault <= 1'b0;
    end

    logic [2:0] iev;
    assign iev = {dnld, cap_min | cap_max, trip & ~signal_lost_fault};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ist_q <= 3'h0;
        else ist_q <= iev | (ist_q & ~((wr && paddr == `IOP_A_ISTAT) ? pwdata[2:0] : 3'h0));
    end
    assign irq = |(ist_q & imask_q);

    fault_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
        signal_lost_fault && !frst |=> signal_lost_fault)
        else $error("fault dropped without reset");
    fault_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        trip |=> signal_lost_fault) else $error("trip did not fault");
    force_on_a: assert property (@(posedge pclk) disable iff (!presetn)
        force_q[0] |=> dout_pin[0]) else $error("force on ignored");
    out_pol_a: assert property (@(posedge pclk) disable iff (!presetn)
        force_q[8] == 1'b0 && force_q[0] == 1'b0 |=>
        dout_pin[0] == ($past(func_out[iop_fld3(omap_act_q, 0)]) ^ $past(pol_q[8])))
        else $error("output polarity wrong");
    cap_min_a: assert property (@(posedge pclk) disable iff (!presetn)
        cap_min |=> vmin_q == $past(x_q)) else $error("capture min wrong");
    sequence s_dnld; dnld; endsequence
    sequence s_saved; vmin_sv_q == $past(vmin_q) && imap_act_q == $past(imap_q); endsequence
    dnld_commit_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_dnld |=> s_saved) else $error("download not committed");
    map_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !dnld |=> $stable(imap_act_q) && $stable(omap_act_q))
        else $error("map changed without download");
    freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
        ana_hold && !(wr && paddr == `IOP_A_BW) |=> $stable(filt_q))
        else $error("filter moved at zero frequency");
    irq_lvl_a: assert property (@(posedge pclk) disable iff (!presetn)
        trip && !signal_lost_fault && imask_q[0] && !(wr && paddr == `IOP_A_IMASK) |=> irq)
        else $error("fault did not raise irq");
    div_done_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == IOP_DIV_IDLE ##1 st_q == IOP_DIV_RUN |-> ##[34:36] st_q == IOP_DIV_IDLE)
        else $error("scaling did not finish");
    div_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        go_q && st_q == IOP_DIV_IDLE && den_w > 0 |=> st_q == IOP_DIV_RUN)
        else $error("scaling did not start");
    unip_clip_a: assert property (@(posedge pclk) disable iff (!presetn)
        adc_valid && HAS_RANGE && ctrl_q[`IOP_C_UNIP] |=> !x_q[15])
        else $error("unipolar sample went negative");
endmodule : iop_top

// ===== hw/iop_params.svh
/*
 * offsets, field positions, reset values and filter constants for the
 * field i/o conditioner. assumes a 32-bit apb with byte addresses.
 */
`ifndef IOP_PARAMS_SVH
`define IOP_PARAMS_SVH
`define IOP_A_CTRL    12'h000
`define IOP_A_POL     12'h004
`define IOP_A_FORCE   12'h008
`define IOP_A_IMAP    12'h00C
`define IOP_A_OMAP    12'h010
`define IOP_A_VIO     12'h014
`define IOP_A_BW      12'h018
`define IOP_A_VMIN    12'h01C
`define IOP_A_VMAX    12'h020
`define IOP_A_TRIPLO  12'h024
`define IOP_A_TRIPHI  12'h028
`define IOP_A_CMDMIN  12'h02C
`define IOP_A_CMDMAX  12'h030
`define IOP_A_IOSTAT  12'h034
`define IOP_A_ANASTAT 12'h038
`define IOP_A_ISTAT   12'h03C
`define IOP_A_IMASK   12'h040
`define IOP_A_SAVED   12'h044
`define IOP_C_DNLD    0
`define IOP_C_CAPMIN  1
`define IOP_C_CAPMAX  2
`define IOP_C_FRST    3
`define IOP_C_UNIP    4
`define IOP_C_LOEN    5
`define IOP_C_HIEN    6
`define IOP_C_LEGACY  7
`define IOP_C_FACT    8
`define IOP_I_LOST    0
`define IOP_I_CAP     1
`define IOP_I_DNLD    2
`define IOP_RST_VMIN  16'h8001
`define IOP_RST_VMAX  16'h7FFF
`define IOP_RST_BW    16'h0002
`define IOP_SAMPLE_HZ 1000
`define IOP_DIV_STEPS 34
`endif

// ===== hw/iop_pkg.sv
/*
 * types and shared decode for the field i/o conditioner.
 * assumes iop_params.svh is on the include path.
 */
package iop_pkg;
    typedef enum logic {IOP_DIV_IDLE, IOP_DIV_RUN} iop_div_st_t;
    typedef logic [2:0] iop_sel_t;

    function automatic iop_sel_t iop_fld3(input logic [31:0] v, input int i);
        iop_fld3 = v[3*i +: 3];
    endfunction : iop_fld3
endpackage : iop_pkg

// ===== verification/iop_field_host.sv
/*
 * field-side host model: drives input pins, output functions and adc samples.
 * assumes one bench thread calls its tasks, all timed on pclk.
 */
`timescale 1ns/1ps
module iop_field_host (
    input  wire logic        pclk,
    output logic      [7:0]  din_pin,
    output logic      [7:0]  func_out,
    output logic      [15:0] adc_data,
    output logic             adc_valid
);
    // pins and sample data stay unknown until first driven; nothing reads them before
    initial begin
        func_out  = 8'h00;
        adc_valid = 1'b0;
    end

    task automatic set_lines(input logic [7:0] pins, input logic [7:0] funcs);
        @(posedge pclk);
        din_pin  <= pins;
        func_out <= funcs;
    endtask : set_lines

    // the endpoint voltage is applied before any capture request follows
    task automatic sample(input logic [15:0] v);
        @(posedge pclk);
        adc_data  <= v;
        adc_valid <= 1'b1;
        @(posedge pclk);
        adc_valid <= 1'b0;
        // data only counts with the strobe, so show garbage afterwards
        adc_data  <= ~v;
    endtask : sample
endmodule : iop_field_host

// ===== verification/tb_top.sv
/*
 * self-checking bench for the field i/o conditioner over apb.
 * assumes iop_params.svh on the include path and default parameters.
 */
`timescale 1ns/1ps
`include "iop_params.svh"
module tb_top;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        adc_valid, signal_lost_fault, ana_hold, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  din_pin, func_out, func_in;
    logic [3:0]  dout_pin;
    logic [15:0] adc_data, ana_cmd;
    int          err_count, n_checks;

    iop_top iop_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .din_pin(din_pin), .func_out(func_out), .func_in(func_in),
        .dout_pin(dout_pin), .adc_data(adc_data), .adc_valid(adc_valid), .ana_cmd(ana_cmd),
        .signal_lost_fault(signal_lost_fault), .ana_hold(ana_hold), .irq(irq));
    iop_field_host iop_field_host_i (.pclk(pclk), .din_pin(din_pin), .func_out(func_out),
        .adc_data(adc_data), .adc_valid(adc_valid));

    always #5 pclk = ~pclk;

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            complete_run();
        end else begin
            rd = prdata;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask : wr

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
        xfer(a, 1'b0, 32'h0);
        chk(rd & m, exp);
    endtask : rchk

    // ana_cmd trails a sample by a long divide, so poll it with a bound
    task automatic wait_cmd(input logic [15:0] exp);
        int n;
        n = 0;
        while (ana_cmd !== exp && n < 200) begin
            @(posedge pclk);
            n++;
        end
        chk({16'h0, ana_cmd}, {16'h0, exp});
    endtask : wait_cmd

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        err_count = 0;
        n_checks = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rchk(`IOP_A_BW, 32'h2, ALL);
        rchk(`IOP_A_VMIN, 32'h8001, ALL);
        rchk(`IOP_A_VMAX, 32'h7FFF, ALL);
        xfer(12'h048, 1'b0, 32'h0);
        chk({31'h0, pslverr}, 32'h1);
        chk(rd, 32'h0);
        wr(`IOP_A_CTRL, 32'h80);
        rchk(`IOP_A_CTRL, 32'h0, 32'h80);
        $display("test registers done");
        iop_field_host_i.sample(16'h4000);
        repeat (3) @(posedge pclk);
        rchk(`IOP_A_ANASTAT, 32'hCE, 32'hFFFF);
        wr(`IOP_A_BW, 32'h0);
        @(posedge pclk);
        chk({31'h0, ana_hold}, 32'h1);
        iop_field_host_i.sample(16'h7000);
        repeat (3) @(posedge pclk);
        rchk(`IOP_A_ANASTAT, 32'hCE, 32'hFFFF);
        $display("test filter done");
        wr(`IOP_A_IMAP, 32'hFAC688);
        wr(`IOP_A_OMAP, 32'h688);
        wr(`IOP_A_CTRL, 32'h1);
        iop_field_host_i.set_lines(8'hA5, 8'h05);
        repeat (5) @(posedge pclk);
        chk({24'h0, func_in}, 32'hA5);
        chk({28'h0, dout_pin}, 32'h5);
        rchk(`IOP_A_IOSTAT, 32'hA50500A5, 32'hFF0F00FF);
        wr(`IOP_A_POL, 32'hFFF);
        repeat (5) @(posedge pclk);
        chk({24'h0, func_in}, 32'h5A);
        chk({28'h0, dout_pin}, 32'hA);
        wr(`IOP_A_POL, 32'h0);
        wr(`IOP_A_IMAP, 32'h053977);
        iop_field_host_i.set_lines(8'h01, 8'h00);
        repeat (5) @(posedge pclk);
        chk({24'h0, func_in}, 32'h01);
        wr(`IOP_A_CTRL, 32'h1);
        repeat (5) @(posedge pclk);
        chk({24'h0, func_in}, 32'h80);
        wr(`IOP_A_IMAP, 32'hFAC688);
        wr(`IOP_A_CTRL, 32'h1);
        wr(`IOP_A_FORCE, 32'hC09);
        iop_field_host_i.set_lines(8'h00, 8'h04);
        repeat (3) @(posedge pclk);
        chk({28'h0, dout_pin}, 32'h9);
        wr(`IOP_A_FORCE, 32'h0);
        wr(`IOP_A_VIO, 32'h174F1);
        iop_field_host_i.set_lines(8'h80, 8'h06);
        repeat (5) @(posedge pclk);
        chk({24'h0, func_in}, 32'h40);
        iop_field_host_i.set_lines(8'h00, 8'h00);
        $display("test digital done");
        wr(`IOP_A_BW, 32'd200);
        wr(`IOP_A_VMIN, 32'h0);
        wr(`IOP_A_VMAX, 32'h4000);
        wr(`IOP_A_CMDMIN, 32'h100);
        wr(`IOP_A_CMDMAX, 32'h1000);
        iop_field_host_i.sample(16'h2000);
        wait_cmd(16'h0880);
        wr(`IOP_A_CTRL, 32'h10);
        iop_field_host_i.sample(16'hE000);
        wait_cmd(16'h0100);
        wr(`IOP_A_CTRL, 32'h0);
        iop_field_host_i.sample(16'h0800);
        wait_cmd(16'h02E0);
        $display("test scaling done");
        wr(`IOP_A_TRIPHI, 32'h1000);
        wr(`IOP_A_TRIPLO, 32'hF000);
        wr(`IOP_A_ISTAT, 32'h7);
        wr(`IOP_A_IMASK, 32'h1);
        wr(`IOP_A_CTRL, 32'h140);
        iop_field_host_i.sample(16'h2000);
        repeat (2) @(posedge pclk);
        chk({31'h0, signal_lost_fault}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wait_cmd(16'h0100);
        iop_field_host_i.sample(16'h0800);
        repeat (2) @(posedge pclk);
        chk({31'h0, signal_lost_fault}, 32'h1);
        wr(`IOP_A_IMASK, 32'h0);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        wr(`IOP_A_CTRL, 32'h148);
        repeat (2) @(posedge pclk);
        chk({31'h0, signal_lost_fault}, 32'h0);
        wr(`IOP_A_ISTAT, 32'h1);
        rchk(`IOP_A_ISTAT, 32'h0, 32'h1);
        wr(`IOP_A_CTRL, 32'h20);
        iop_field_host_i.sample(16'hE000);
        repeat (2) @(posedge pclk);
        chk({31'h0, signal_lost_fault}, 32'h1);
        wr(`IOP_A_CTRL, 32'h08);
        @(posedge pclk);
        chk({31'h0, signal_lost_fault}, 32'h1);
        wr(`IOP_A_CTRL, 32'h08);
        @(posedge pclk);
        chk({31'h0, signal_lost_fault}, 32'h0);
        $display("test trip done");
        wr(`IOP_A_ISTAT, 32'h7);
        iop_field_host_i.sample(16'h1234);
        repeat (2) @(posedge pclk);
        wr(`IOP_A_CTRL, 32'h2);
        rchk(`IOP_A_VMIN, 32'h1234, ALL);
        iop_field_host_i.sample(16'h3456);
        repeat (2) @(posedge pclk);
        wr(`IOP_A_CTRL, 32'h4);
        rchk(`IOP_A_VMAX, 32'h3456, ALL);
        rchk(`IOP_A_ISTAT, 32'h2, 32'h2);
        rchk(`IOP_A_SAVED, 32'h7FFF8001, ALL);
        wr(`IOP_A_CTRL, 32'h1);
        rchk(`IOP_A_SAVED, 32'h34561234, ALL);
        $display("test capture done");
        complete_run();
    end
endmodule : tb_top
